// ==== design/shcd_map.vh ====
/*
  address, command, status and timing constants for the sensor hub
  command decoder. assumes inclusion by bare name from design files.
*/
`ifndef SHCD_MAP_VH
`define SHCD_MAP_VH
`define SHCD_DEF_ADDR8 8'hAA
`define SHCD_FAM_STATUS 8'h00
`define SHCD_FAM_MODE_SET 8'h01
`define SHCD_FAM_MODE_GET 8'h02
`define SHCD_FAM_OUT_SET 8'h10
`define SHCD_IDX_0 8'h00
`define SHCD_IDX_THRESH 8'h01
`define SHCD_IDX_PERIOD 8'h02
`define SHCD_IDX_ADDR 8'h03
`define SHCD_IDX_COUNTER 8'h04
`define SHCD_MODE_APP 8'h00
`define SHCD_MODE_SHDN 8'h01
`define SHCD_MODE_RESET 8'h02
`define SHCD_MODE_BOOT 8'h08
`define SHCD_ST_OK 8'h00
`define SHCD_ST_BAD_CMD 8'h01
`define SHCD_ST_BAD_LEN 8'h03
`define SHCD_ST_BAD_VAL 8'h04
`define SHCD_BIT_COMM 0
`define SHCD_BIT_RDY 3
`define SHCD_BIT_OOVF 4
`define SHCD_BIT_IOVF 5
`define SHCD_BIT_IUNF 6
`define SHCD_FMT_RST 3'h0
`define SHCD_THRESH_RST 8'h01
`define SHCD_PERIOD_RST 8'h01
`define SHCD_CLK_MHZ 125
`define SHCD_CMD_DELAY_US 2000
`endif

// ==== design/shcd_i2c_target.v ====
/*
  i2c target byte engine: start/stop detection, address match, byte
  receive with ack, byte transmit. assumes scl and sda already synced.
*/
`default_nettype none
`include "shcd_map.vh"
module shcd_i2c_target (
  input wire clk,
  input wire sys_rst,
  input wire scl_s,
  input wire sda_s,
  input wire [7:0] addr8,
  input wire [7:0] tx_byte,
  output reg sda_oe_q,
  output reg start_q,
  output reg stop_q,
  output reg rx_valid_q,
  output reg [7:0] rx_byte_q,
  output reg rd_q,
  output reg tx_take_q
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_RX = 3'h2;
  localparam ST_TX = 3'h3;
  localparam ST_ACK = 3'h4;
  localparam ST_MACK = 3'h5;
  reg scl_p_q;
  reg sda_p_q;
  reg [2:0] st_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q;
  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // bit engine, ack driven on falling scl after 8th bit
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      sda_oe_q <= 1'b0;
      start_q <= 1'b0;
      stop_q <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_byte_q <= 8'h00;
      rd_q <= 1'b0;
      tx_take_q <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      start_q <= start_c;
      stop_q <= stop_c;
      rx_valid_q <= 1'b0;
      tx_take_q <= 1'b0;
      if (start_c) begin
        st_q <= ST_ADDR;
        cnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
      end else if (stop_c) begin
        st_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
      end else begin
        case (st_q)
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'h8) begin
              cnt_q <= 4'h0;
              if (st_q == ST_ADDR) begin
                if (sh_q[7:1] == addr8[7:1]) begin
                  sda_oe_q <= 1'b1;
                  rd_q <= sh_q[0];
                  st_q <= ST_ACK;
                end else begin
                  st_q <= ST_IDLE;
                end
              end else begin
                rx_byte_q <= sh_q;
                rx_valid_q <= 1'b1;
                sda_oe_q <= 1'b1;
                st_q <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (rd_q) begin
                sh_q <= tx_byte;
                tx_take_q <= 1'b1;
                sda_oe_q <= ~tx_byte[7];
                cnt_q <= 4'h1;
                st_q <= ST_TX;
              end else begin
                sda_oe_q <= 1'b0;
                st_q <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (cnt_q == 4'h8) begin
                sda_oe_q <= 1'b0;
                st_q <= ST_MACK;
              end else begin
                sda_oe_q <= ~sh_q[3'h7 - cnt_q[2:0]];
                cnt_q <= cnt_q + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              st_q <= sda_s ? ST_IDLE : ST_ACK;
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== design/shcd_decoder.v ====
/*
  sensor hub command decoder: family/index/write-byte commands over an
  i2c target port. assumes a host master on scl/sda, open-drain wiring.
*/
`default_nettype none
`include "shcd_map.vh"
module shcd_decoder (
  input wire clk,
  input wire sys_rst,
  input wire scl_in,
  input wire sda_in,
  output reg sda_oe_q,
  output reg sda_out_q,
  input wire sensor_comm_error,
  input wire [7:0] fifo_level,
  input wire out_queue_overflow_ev,
  input wire in_queue_overflow_ev,
  input wire in_queue_underflow_ev,
  input wire sample_tick,
  output reg multifunction_pin_q,
  output reg report_pulse_q,
  output reg counter_prefix_q,
  output reg [2:0] out_format_q,
  output reg boot_mode_q,
  output reg shutdown_q,
  output reg soft_reset_q,
  output reg [7:0] hub_counter_q,
  output reg [7:0] i2c_addr_q
);
  localparam integer CMD_DELAY_CYC = `SHCD_CMD_DELAY_US * `SHCD_CLK_MHZ;
  reg scl_m_q, scl_s_q, sda_m_q, sda_s_q;
  reg [7:0] thresh_q, period_q, period_cnt_q;
  reg [7:0] fam_q, idx_q, wr_q, result_q;
  reg [1:0] nbytes_q;
  reg [1:0] rd_ptr_q;
  reg oovf_q, iovf_q, iunf_q;
  wire sda_oe_c, start_p, stop_p, rx_v, rd_dir, tx_take;
  wire [7:0] rx_b;
  reg [7:0] tx_c;
  wire fifo_threshold_flag = (fifo_level >= thresh_q);
  wire [7:0] hub_status_byte = {1'b0, iunf_q, iovf_q, oovf_q, fifo_threshold_flag,
                                2'b00, sensor_comm_error};

  // two-flop synchronisers on the pins
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      scl_m_q <= scl_in;
      scl_s_q <= scl_m_q;
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
    end
  end

  shcd_i2c_target u_tgt (
    .clk(clk),
    .sys_rst(sys_rst),
    .scl_s(scl_s_q),
    .sda_s(sda_s_q),
    .addr8(i2c_addr_q),
    .tx_byte(tx_c),
    .sda_oe_q(sda_oe_c),
    .start_q(start_p),
    .stop_q(stop_p),
    .rx_valid_q(rx_v),
    .rx_byte_q(rx_b),
    .rd_q(rd_dir),
    .tx_take_q(tx_take)
  );

  // response bytes: result first, then data; answers are formed at once,
  // well inside the host wait
  always @* begin
    tx_c = 8'h00;
    if (rd_ptr_q == 2'h0) begin
      tx_c = result_q;
    end else if (result_q == `SHCD_ST_OK) begin
      if (fam_q == `SHCD_FAM_STATUS) begin
        tx_c = hub_status_byte;
      end else if (fam_q == `SHCD_FAM_MODE_GET) begin
        tx_c = boot_mode_q ? `SHCD_MODE_BOOT : `SHCD_MODE_APP;
      end
    end
  end

  // command capture, response pointer
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fam_q <= 8'h00;
      idx_q <= 8'h00;
      wr_q <= 8'h00;
      nbytes_q <= 2'h0;
      rd_ptr_q <= 2'h0;
    end else begin
      if (start_p) begin
        rd_ptr_q <= 2'h0;
      end
      if (tx_take && rd_ptr_q != 2'h3) begin
        rd_ptr_q <= rd_ptr_q + 2'h1;
      end
      // direction of the new frame is not known yet at start, so always
      // restart the byte count; a read frame never executes a command
      if (start_p) begin
        nbytes_q <= 2'h0;
      end
      if (rx_v) begin
        if (nbytes_q != 2'h3) begin
          nbytes_q <= nbytes_q + 2'h1;
        end
        case (nbytes_q)
          2'h0: fam_q <= rx_b;
          2'h1: idx_q <= rx_b;
          2'h2: wr_q <= rx_b;
          default: wr_q <= wr_q;
        endcase
      end
    end
  end

  // execute at the write stop, set result and configuration
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_q <= `SHCD_ST_OK;
      out_format_q <= `SHCD_FMT_RST;
      thresh_q <= `SHCD_THRESH_RST;
      period_q <= `SHCD_PERIOD_RST;
      i2c_addr_q <= `SHCD_DEF_ADDR8;
      hub_counter_q <= 8'h00;
      boot_mode_q <= 1'b0;
      shutdown_q <= 1'b0;
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= 1'b0;
      if (stop_p && !rd_dir && nbytes_q != 2'h0) begin
        result_q <= `SHCD_ST_OK;
        if (idx_q != `SHCD_IDX_0 && fam_q != `SHCD_FAM_OUT_SET) begin
          result_q <= `SHCD_ST_BAD_CMD;
        end else begin
          case (fam_q)
            `SHCD_FAM_STATUS, `SHCD_FAM_MODE_GET: begin
              if (nbytes_q != 2'h2) result_q <= `SHCD_ST_BAD_LEN;
            end
            `SHCD_FAM_MODE_SET: begin
              if (nbytes_q != 2'h3) begin
                result_q <= `SHCD_ST_BAD_LEN;
              end else begin
                case (wr_q)
                  `SHCD_MODE_APP: boot_mode_q <= 1'b0;
                  `SHCD_MODE_SHDN: shutdown_q <= 1'b1;
                  `SHCD_MODE_RESET: soft_reset_q <= 1'b1;
                  `SHCD_MODE_BOOT: boot_mode_q <= 1'b1;
                  default: result_q <= `SHCD_ST_BAD_VAL;
                endcase
              end
            end
            `SHCD_FAM_OUT_SET: begin
              if (nbytes_q != 2'h3) begin
                result_q <= `SHCD_ST_BAD_LEN;
              end else begin
                case (idx_q)
                  `SHCD_IDX_0: begin
                    if (wr_q[7:3] != 5'h00) result_q <= `SHCD_ST_BAD_VAL;
                    else out_format_q <= wr_q[2:0];
                  end
                  `SHCD_IDX_THRESH: begin
                    if (wr_q == 8'h00) result_q <= `SHCD_ST_BAD_VAL;
                    else thresh_q <= wr_q;
                  end
                  `SHCD_IDX_PERIOD: begin
                    if (wr_q == 8'h00) result_q <= `SHCD_ST_BAD_VAL;
                    else period_q <= wr_q;
                  end
                  `SHCD_IDX_ADDR: i2c_addr_q <= wr_q;
                  `SHCD_IDX_COUNTER: hub_counter_q <= wr_q;
                  default: result_q <= `SHCD_ST_BAD_CMD;
                endcase
              end
            end
            default: result_q <= `SHCD_ST_BAD_CMD;
          endcase
        end
      end
    end
  end

  // sticky event flags, cleared by reset only
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      oovf_q <= 1'b0;
      iovf_q <= 1'b0;
      iunf_q <= 1'b0;
    end else begin
      if (out_queue_overflow_ev) oovf_q <= 1'b1;
      if (in_queue_overflow_ev) iovf_q <= 1'b1;
      if (in_queue_underflow_ev) iunf_q <= 1'b1;
    end
  end

  // reporting cadence, interrupt pin, sda drive
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      period_cnt_q <= 8'h00;
      report_pulse_q <= 1'b0;
      multifunction_pin_q <= 1'b1;
      counter_prefix_q <= 1'b0;
      sda_oe_q <= 1'b0;
      sda_out_q <= 1'b0;
    end else begin
      report_pulse_q <= 1'b0;
      if (sample_tick && !shutdown_q && out_format_q[1:0] != 2'b00) begin
        if (period_cnt_q + 8'h01 >= period_q) begin
          period_cnt_q <= 8'h00;
          report_pulse_q <= 1'b1;
        end else begin
          period_cnt_q <= period_cnt_q + 8'h01;
        end
      end
      multifunction_pin_q <= ~fifo_threshold_flag;
      counter_prefix_q <= out_format_q[2] & (out_format_q[1:0] != 2'b00);
      sda_oe_q <= sda_oe_c & ~shutdown_q;
      sda_out_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== verification/shcd_decoder_monitor.sv ====
/* checker on the command decoder top ports.
   assumes a bind into every decoder instance. */
`default_nettype none
module shcd_decoder_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe_q,
  input wire logic [7:0] fifo_level,
  input wire logic sample_tick,
  input wire logic multifunction_pin_q,
  input wire logic report_pulse_q,
  input wire logic counter_prefix_q,
  input wire logic [2:0] out_format_q,
  input wire logic boot_mode_q,
  input wire logic shutdown_q,
  input wire logic soft_reset_q,
  input wire logic [7:0] hub_counter_q,
  input wire logic [7:0] i2c_addr_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // interrupt pin against a threshold of 1..255
  chk_irq_pin_empty: assert property ((fifo_level == 8'h00) [*3] |-> multifunction_pin_q)
    else $error("interrupt pin low with empty fifo");
  chk_irq_pin_full: assert property ((fifo_level == 8'hFF) [*3] |-> !multifunction_pin_q)
    else $error("interrupt pin high with full fifo");
  // mode side effects
  chk_rst_pulse: assert property (soft_reset_q |=> !soft_reset_q)
    else $error("soft reset longer than one cycle");
  chk_shdn_hold: assert property (shutdown_q |=> shutdown_q)
    else $error("shutdown left without reset");
  // format decode and reporting
  chk_prefix_fmt: assert property ($stable(out_format_q) |->
    counter_prefix_q == (out_format_q > 3'h4)) else $error("prefix mismatch");
  chk_pause_quiet: assert property ($stable(out_format_q) && out_format_q[1:0] == 2'b00
    |-> !report_pulse_q) else $error("report while paused");
  chk_pulse_tick: assert property (report_pulse_q |-> $past(sample_tick) ||
    $past(sample_tick, 2)) else $error("report without sample");
  // config moves only after a stop, bus idle
  chk_cfg_stop: assert property (!$stable({out_format_q, boot_mode_q, hub_counter_q,
    i2c_addr_q}) |-> scl_in && sda_in) else $error("config changed mid frame");
  chk_sda_scl_low: assert property (!$stable(sda_oe_q) |-> !scl_in)
    else $error("sda moved while scl high");
  cov_soft_reset: cover property (soft_reset_q);
  cov_boot: cover property ($rose(boot_mode_q));
  cov_report: cover property (report_pulse_q);
endmodule
bind shcd_decoder shcd_decoder_monitor mon (.clk, .sys_rst, .scl_in, .sda_in, .sda_oe_q,
  .fifo_level, .sample_tick, .multifunction_pin_q, .report_pulse_q, .counter_prefix_q,
  .out_format_q, .boot_mode_q, .shutdown_q, .soft_reset_q, .hub_counter_q, .i2c_addr_q);
`default_nettype wire

// ==== verification/shcd_host_model.sv ====
/* host model: i2c master bit and byte tasks.
   assumes the bench resolves sda with a pull-up. */
`default_nettype none
module shcd_host_model (
  input wire logic clk,
  input wire logic sda,
  output var logic scl,
  output var logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int H = 8;
  // bus idle, scl stands high between frames
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one bit out, data moves only with scl low
  task automatic wbit(input logic b);
    sda_oe <= ~b;
    tk(H);
    scl <= 1'b1;
    tk(H);
    scl <= 1'b0;
    tk(1);
  endtask
  // one bit in, sampled mid high phase
  task automatic rbit(output logic b);
    sda_oe <= 1'b0;
    tk(H);
    scl <= 1'b1;
    tk(H / 2);
    b = sda;
    tk(H / 2);
    scl <= 1'b0;
    tk(1);
  endtask
  task automatic frame_start();
    sda_oe <= 1'b1;
    tk(H);
    scl <= 1'b0;
    tk(1);
  endtask
  // stop, then a 2 * H cycle gap before the next frame
  task automatic frame_stop();
    sda_oe <= 1'b1;
    tk(H);
    scl <= 1'b1;
    tk(H);
    sda_oe <= 1'b0;
    tk(2 * H);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic a);
    logic b;
    for (int i = 7; i >= 0; i--) wbit(d[i]);
    rbit(b);
    a = ~b;
  endtask
  task automatic rbyte(output logic [7:0] d, input logic nack);
    for (int i = 7; i >= 0; i--) rbit(d[i]);
    wbit(nack);
  endtask
endmodule
`default_nettype wire

// ==== verification/shcd_decoder_tb_top.sv ====
/* bench top: host model on the pins, checker bound in.
   assumes the decoder and its map header are compiled. */
`default_nettype none
module shcd_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sensor_comm_error = 1'b0;
  logic [7:0] fifo_level = 8'h00;
  logic out_queue_overflow_ev = 1'b0;
  logic in_queue_overflow_ev = 1'b0;
  logic in_queue_underflow_ev = 1'b0;
  logic sample_tick = 1'b0;
  logic sda_oe_q, sda_out_q, multifunction_pin_q, report_pulse_q, counter_prefix_q;
  logic boot_mode_q, shutdown_q, soft_reset_q;
  logic [2:0] out_format_q;
  logic [7:0] hub_counter_q, i2c_addr_q, v;
  logic [7:0] adr = 8'hAA;
  logic [7:0] tgt = 8'hAA;
  wire logic scl_in, host_oe;
  wire logic sda_in = ~(sda_oe_q | host_oe);
  int failures, comparisons, cyc, pulses, resets, p0, seed;
  always #4 clk = ~clk;
  shcd_decoder dut (.clk, .sys_rst, .scl_in, .sda_in, .sda_oe_q, .sda_out_q, .sensor_comm_error,
    .fifo_level, .out_queue_overflow_ev, .in_queue_overflow_ev, .in_queue_underflow_ev,
    .sample_tick, .multifunction_pin_q, .report_pulse_q, .counter_prefix_q, .out_format_q,
    .boot_mode_q, .shutdown_q, .soft_reset_q, .hub_counter_q, .i2c_addr_q);
  shcd_host_model host (.clk, .sda(sda_in), .scl(scl_in), .sda_oe(host_oe));
  // pulse counts and hang limit
  always @(posedge clk) begin
    pulses <= pulses + int'(report_pulse_q);
    resets <= resets + int'(soft_reset_q);
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      $display("BAD %0t run limit reached", $time);
      failures++;
      test_done();
    end
  end
  function automatic logic [7:0] st(input logic c, r, oo, io, iu);
    return {1'b0, iu, io, oo, r, 2'b00, c};
  endfunction
  task automatic chk(input logic [7:0] got, exp, input string m);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] f, i, input int n, input logic [7:0] d);
    logic a;
    host.frame_start();
    host.wbyte(adr, a);
    chk({7'h00, a}, {7'h00, adr == tgt}, "ack");
    host.wbyte(f, a);
    host.wbyte(i, a);
    if (n > 0) host.wbyte(d, a);
    host.frame_stop();
  endtask
  task automatic rd(input logic [7:0] er, ed);
    logic a;
    logic [7:0] r, d;
    host.frame_start();
    host.wbyte(adr | 8'h01, a);
    host.rbyte(r, 1'b0);
    host.rbyte(d, 1'b1);
    host.frame_stop();
    chk(r, er, "result");
    chk(d, ed, "data");
  endtask
  task automatic test_done();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // main sequence
  initial begin
    seed = 52400;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    cmd(8'h00, 8'h00, 0, 8'h00);
    rd(8'h00, st(0, 0, 0, 0, 0));
    sensor_comm_error <= 1'b1;
    fifo_level <= 8'h01;
    {out_queue_overflow_ev, in_queue_overflow_ev, in_queue_underflow_ev} <= 3'b111;
    @(posedge clk);
    {out_queue_overflow_ev, in_queue_overflow_ev, in_queue_underflow_ev} <= 3'b000;
    cmd(8'h00, 8'h00, 0, 8'h00);
    rd(8'h00, st(1, 1, 1, 1, 1));
    cmd(8'h00, 8'h00, 1, 8'h00);
    rd(8'h03, 8'h00);
    cmd(8'h55, 8'h00, 0, 8'h00);
    rd(8'h01, 8'h00);
    for (int k = 0; k < 2; k++) begin
      v = k ? 8'h00 : 8'h08;
      cmd(8'h01, 8'h00, 1, v);
      rd(8'h00, 8'h00);
      cmd(8'h02, 8'h00, 0, 8'h00);
      rd(8'h00, v);
      chk({7'h00, boot_mode_q}, v >> 3, "boot");
    end
    cmd(8'h01, 8'h00, 1, 8'h03);
    rd(8'h04, 8'h00);
    cmd(8'h01, 8'h00, 1, 8'h02);
    chk(8'(resets), 8'h01, "soft reset");
    for (int c = 0; c < 8; c++) begin
      cmd(8'h10, 8'h00, 1, 8'(c));
      rd(8'h00, 8'h00);
      chk({5'h00, out_format_q}, 8'(c), "format");
      chk({7'h00, counter_prefix_q}, {7'h00, c > 4}, "prefix");
    end
    cmd(8'h10, 8'h02, 1, 8'h03);
    rd(8'h00, 8'h00);
    for (int k = 7; k >= 4; k -= 3) begin
      cmd(8'h10, 8'h00, 1, 8'(k));
      p0 = pulses;
      repeat (9) begin
        sample_tick <= 1'b1;
        @(posedge clk);
        sample_tick <= 1'b0;
        repeat (2 + $unsigned($random(seed)) % 4) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      chk(8'(pulses - p0), k == 7 ? 8'h03 : 8'h00, "reports");
    end
    cmd(8'h10, 8'h01, 1, 8'h00);
    rd(8'h04, 8'h00);
    v = 8'($random(seed)) | 8'h02;
    cmd(8'h10, 8'h01, 1, v);
    rd(8'h00, 8'h00);
    for (int k = 0; k < 3; k++) begin
      fifo_level <= k == 2 ? 8'hFF : v - 8'(1 - k);
      repeat (4) @(posedge clk);
      chk({7'h00, multifunction_pin_q}, {7'h00, k == 0}, "irq pin");
      cmd(8'h00, 8'h00, 0, 8'h00);
      rd(8'h00, st(1, k != 0, 1, 1, 1));
    end
    v = 8'($random(seed));
    cmd(8'h10, 8'h04, 1, v);
    rd(8'h00, 8'h00);
    chk(hub_counter_q, v, "counter");
    cmd(8'h10, 8'h03, 1, 8'hB4);
    chk(i2c_addr_q, 8'hB4, "address");
    tgt = 8'hB4;
    cmd(8'h01, 8'h00, 1, 8'h01);
    chk({7'h00, shutdown_q}, 8'h00, "ignored");
    adr = 8'hB4;
    cmd(8'h01, 8'h00, 1, 8'h01);
    chk({7'h00, shutdown_q}, 8'h01, "shutdown");
    chk({7'h00, sda_out_q}, 8'h00, "sda level");
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk({7'h00, shutdown_q}, 8'h00, "restart");
    chk(i2c_addr_q, 8'hAA, "addr reset");
    test_done();
  end
endmodule
`default_nettype wire
